// >>> hw/rbs_bit_sync.sv
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// R1 - Receive mode field sits at control bits 15..14 choosing four behaviours.
// R2 - Raw mode passes slicer data through; clock and flag held low.
// R3 - Deglitch sampling rate is reference clock over first times second divisor.
// R4 - Filter goes high at five of seven, low at two or fewer, else holds.
// R5 - Deglitch mode outputs sampling clock, flag low, data after rising edge.
// R6 - Deglitch mode data changes just after rising edge of data clock.
// R7 - Mode 10 aligns bit clock to deglitched edges and outputs both.
// R8 - Sender keeps identical-bit runs below 250000 over rate mismatch in ppm.
// R9 - Recovered data changes on falling clock edge; controller captures on rising.
// R10 - Recovered clock stays low after reset until a data edge is seen.
// R11 - Recovered clock rising edge sits at the centre of each bit.
// R12 - Mode 11 recovers clock and data while watching for end of training.
// R13 - Control bit 12 selects single or paired alternating training pattern.
// R14 - Flag pulses one bit period at first bit breaking a long enough training.
// R15 - Minimum training length is four times count field plus select plus two.
// R16 - Recovery and training logic restart on their own without software help.
// R17 - Bit rate is reference clock over the product of three divisors.
// R18 - Sample strobe from a wrapping counter; third divisor counter sets bit period.
// R19 - History and training counter clear whenever receive mode changes.
module rbs_bit_sync (
   // Clock and reset
   input  wire  logic        ref_clk,
   input  wire  logic        rst,
   // APB slave
   input  wire  logic        psel,
   input  wire  logic        penable,
   input  wire  logic        pwrite,
   input  wire  logic [7:0]  paddr,
   input  wire  logic [31:0] pwdata,
   output logic              pready,
   output logic [31:0]       prdata,
   output logic              pslverr,
   // Slicer input, asynchronous
   input  wire  logic        sliceIn,
   // Outputs to the external controller
   output rbs_pkg::rbs_link_s linkOut,
   // Interrupt
   output logic              irq
);

   rbs_pkg::rbs_ctrl_s          ctrl;
   logic [rbs_pkg::EV_WIDTH-1:0] status;
   logic [rbs_pkg::EV_WIDTH-1:0] mask;
   logic [rbs_pkg::EV_WIDTH-1:0] events;
   rbs_pkg::rbs_mode_e          modePrev;
   logic                        modeChg;
   rbs_pkg::rbs_lock_e          lock;

   logic                        sliceMeta;
   logic                        sliceSync;

   logic [10:0]                 prodM1;
   logic [10:0]                 prodHalf;
   logic [10:0]                 sampCnt;
   logic                        sampTick;

   logic [rbs_pkg::DG_DEPTH-1:0] hist;
   logic [rbs_pkg::DG_DEPTH-1:0] next_hist;
   logic [2:0]                  ones;
   logic                        filt;
   logic                        next_filt;
   logic                        filtEdge;

   logic [4:0]                  div3;
   logic [4:0]                  phase;
   logic                        atEnd;
   logic                        atCentre;

   logic                        prev1;
   logic                        prev2;
   logic [6:0]                  trainCnt;
   logic [6:0]                  trainMin;
   logic                        match;
   logic                        flagArm;

   logic                        access;
   logic                        readStatus;

   function automatic logic [2:0] popcount7(input logic [6:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 7; i++) begin
         n = n + {2'h0, v[i]};
      end
      return n;
   endfunction : popcount7

   // Clock domain entry for the slicer output.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sliceMeta <= 1'b0;
         sliceSync <= 1'b0;
      end else begin
         sliceMeta <= sliceIn;
         sliceSync <= sliceMeta;
      end
   end

   // APB access phase completes one cycle after penable rises.
   assign access     = psel & penable & pready;
   assign readStatus = access & ~pwrite & (paddr == rbs_pkg::ADDR_STATUS);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl <= rbs_pkg::CTRL_RESET;
         mask <= '0;
      end else if (access & pwrite) begin
         if (paddr == rbs_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[15:0]; // R1
         end
         if (paddr == rbs_pkg::ADDR_MASK) begin
            mask <= pwdata[rbs_pkg::EV_WIDTH-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel & penable & ~pready) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         case (paddr)
            rbs_pkg::ADDR_CTRL: begin
               prdata[15:0] <= {ctrl.mode, 1'b0, ctrl.two, ctrl.training_len_count, 1'b0,
                                ctrl.div3Sel, ctrl.div2Sel, ctrl.div1Sel};
            end
            rbs_pkg::ADDR_STATUS: begin
               prdata[rbs_pkg::EV_WIDTH-1:0] <= status;
            end
            rbs_pkg::ADDR_MASK: begin
               prdata[rbs_pkg::EV_WIDTH-1:0] <= mask;
            end
            rbs_pkg::ADDR_STATE: begin
               prdata[rbs_pkg::ST_SEEN] <= (lock == rbs_pkg::LK_TRACK);
               prdata[rbs_pkg::ST_DATA] <= linkOut.rxData;
               prdata[rbs_pkg::ST_CLK]  <= linkOut.dataClk;
               prdata[rbs_pkg::ST_FLAG] <= linkOut.rxFlag;
               prdata[rbs_pkg::ST_CNT_LSB +: 7] <= trainCnt;
            end
            default: begin
               pslverr <= 1'b1;
            end
         endcase
      end
   end

   // A set in the same cycle as the read-clear survives the clear.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status <= '0;
      end else begin
         status <= (readStatus ? '0 : status) | events;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((readStatus ? '0 : status) | events) & mask);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         modePrev <= rbs_pkg::MODE_RAW;
      end else begin
         modePrev <= ctrl.mode;
      end
   end

   assign modeChg = (modePrev != ctrl.mode);

   // Product of first and second divisors, less one, for the sample counter.
   always_comb begin
      logic [10:0] d1;
      d1 = 11'h000;
      case (ctrl.div1Sel)
         2'h0: d1 = {7'h00, rbs_pkg::DIV1_C0};
         2'h1: d1 = {7'h00, rbs_pkg::DIV1_C1};
         2'h2: d1 = {7'h00, rbs_pkg::DIV1_C2};
         default: d1 = {7'h00, rbs_pkg::DIV1_C3};
      endcase
      prodM1   = (d1 << ctrl.div2Sel) - 11'h001; // R17
      prodHalf = (d1 << ctrl.div2Sel) >> 1;
   end

   assign sampTick = (sampCnt == prodM1); // R3

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sampCnt <= 11'h000;
      end else if (sampTick | (sampCnt > prodM1)) begin
         sampCnt <= 11'h000; // R18
      end else begin
         sampCnt <= sampCnt + 11'h001;
      end
   end

   // Majority-style filter over the last seven samples.
   assign next_hist = {hist[rbs_pkg::DG_DEPTH-2:0], sliceSync};
   assign ones      = popcount7(next_hist);

   always_comb begin
      next_filt = filt;
      if (ones >= rbs_pkg::DG_HIGH_TH) begin
         next_filt = 1'b1; // R4
      end else if (ones <= rbs_pkg::DG_LOW_TH) begin
         next_filt = 1'b0; // R4
      end
   end

   assign filtEdge = sampTick & (next_filt != filt);

   always_ff @(posedge ref_clk) begin
      if (rst | modeChg) begin
         hist <= '0; // R19
         filt <= 1'b0;
      end else if (sampTick) begin
         hist <= next_hist;
         filt <= next_filt;
      end
   end

   // Bit period counted in sample ticks.
   assign div3     = ctrl.div3Sel ? rbs_pkg::DIV3_HIGH : {1'b0, rbs_pkg::DIV3_LOW};
   assign atEnd    = sampTick & (phase == div3 - 5'h01); // R18
   assign atCentre = sampTick & ~filtEdge & (phase + 5'h01 == (div3 >> 1));

   always_ff @(posedge ref_clk) begin
      if (rst | modeChg) begin
         phase <= 5'h00; // R16
      end else if (filtEdge | atEnd) begin
         phase <= 5'h00; // R7
      end else if (sampTick) begin
         phase <= phase + 5'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst | modeChg) begin
         lock <= rbs_pkg::LK_WAIT; // R16
      end else begin
         case (lock)
            rbs_pkg::LK_WAIT: begin
               if (filtEdge) begin
                  lock <= rbs_pkg::LK_TRACK;
               end
            end
            rbs_pkg::LK_TRACK: begin
               lock <= rbs_pkg::LK_TRACK;
            end
            default: begin
               lock <= rbs_pkg::LK_WAIT;
            end
         endcase
      end
   end

   // Training pattern checker, evaluated once per bit at its centre.
   assign trainMin = (rbs_pkg::TB_MULT * {2'h0, ctrl.training_len_count})
                     + {6'h00, ctrl.two} + rbs_pkg::TB_OFFSET; // R15

   always_comb begin
      if (ctrl.two) begin
         match = (trainCnt < 7'h02) | (filt != prev2); // R13
      end else begin
         match = (trainCnt < 7'h01) | (filt != prev1); // R13
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst | modeChg) begin
         prev1    <= 1'b0;
         prev2    <= 1'b0;
         trainCnt <= 7'h00; // R19
      end else if (atCentre & (lock == rbs_pkg::LK_TRACK)) begin
         prev1 <= filt;
         prev2 <= prev1;
         if (match) begin
            trainCnt <= (trainCnt == 7'h7F) ? trainCnt : trainCnt + 7'h01;
         end else begin
            trainCnt <= 7'h01; // R16
         end
      end
   end

   assign flagArm = atCentre & (lock == rbs_pkg::LK_TRACK) & ~match
                    & (trainCnt >= trainMin) & (ctrl.mode == rbs_pkg::MODE_TRAIN);

   always_comb begin
      events = '0;
      events[rbs_pkg::EV_TRAIN_END]  = flagArm;
      events[rbs_pkg::EV_FIRST_EDGE] = filtEdge & (lock == rbs_pkg::LK_WAIT)
                                       & ctrl.mode[1];
      events[rbs_pkg::EV_MODE_CHG]   = modeChg;
   end

   // Output stage; each mode drives the three link pins from flops.
   always_ff @(posedge ref_clk) begin
      if (rst | modeChg) begin
         linkOut <= '0;
      end else begin
         case (ctrl.mode)
            rbs_pkg::MODE_RAW: begin
               linkOut.rxData  <= sliceSync; // R2
               linkOut.dataClk <= 1'b0;      // R2
               linkOut.rxFlag  <= 1'b0;      // R2
            end
            rbs_pkg::MODE_DEGLITCH: begin
               linkOut.rxFlag <= 1'b0; // R5
               if (sampTick) begin
                  linkOut.dataClk <= 1'b1;      // R5
                  linkOut.rxData  <= next_filt; // R6
               end else if (sampCnt + 11'h001 == prodHalf) begin
                  linkOut.dataClk <= 1'b0;
               end
            end
            default: begin
               // Data changes as the clock falls at the bit boundary.
               if (filtEdge) begin
                  linkOut.rxData  <= next_filt; // R9
                  linkOut.dataClk <= 1'b0;      // R9
               end else if (atEnd) begin
                  linkOut.rxData  <= filt;
                  linkOut.dataClk <= 1'b0;
               end else if (atCentre) begin
                  linkOut.dataClk <= (lock == rbs_pkg::LK_TRACK); // R10 R11
               end
               if (ctrl.mode != rbs_pkg::MODE_TRAIN) begin
                  linkOut.rxFlag <= 1'b0; // R7
               end else if (flagArm) begin
                  linkOut.rxFlag <= 1'b1; // R12 R14
               end else if (atCentre) begin
                  linkOut.rxFlag <= 1'b0; // R14
               end
            end
         endcase
      end
   end

endmodule : rbs_bit_sync

// >>> hw/rbs_pkg.sv
package rbs_pkg;

   // Register byte addresses on the APB port.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK   = 8'h08;
   localparam logic [7:0] ADDR_STATE  = 8'h0C;

   // Control word reset value: raw mode, all divider codes zero.
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // Status and mask bit positions.
   localparam int EV_TRAIN_END = 0;
   localparam int EV_FIRST_EDGE = 1;
   localparam int EV_MODE_CHG = 2;
   localparam int EV_WIDTH = 3;

   // State register field positions.
   localparam int ST_SEEN = 0;
   localparam int ST_DATA = 1;
   localparam int ST_CLK = 2;
   localparam int ST_FLAG = 3;
   localparam int ST_CNT_LSB = 8;

   // Deglitch filter thresholds over a seven-sample history.
   localparam int         DG_DEPTH   = 7;
   localparam logic [2:0] DG_HIGH_TH = 3'h5;
   localparam logic [2:0] DG_LOW_TH  = 3'h2;

   // Training length equation constants.
   localparam logic [6:0] TB_MULT   = 7'h04;
   localparam logic [6:0] TB_OFFSET = 7'h02;

   // Third divisor choices.
   localparam logic [3:0] DIV3_LOW  = 4'hF;
   localparam logic [4:0] DIV3_HIGH = 5'h10;

   // First divisor choices by code.
   localparam logic [3:0] DIV1_C0 = 4'h1;
   localparam logic [3:0] DIV1_C1 = 4'h5;
   localparam logic [3:0] DIV1_C2 = 4'h6;
   localparam logic [3:0] DIV1_C3 = 4'h8;

   typedef enum logic [1:0] {
      MODE_RAW      = 2'h0,
      MODE_DEGLITCH = 2'h1,
      MODE_RECOVER  = 2'h2,
      MODE_TRAIN    = 2'h3
   } rbs_mode_e;

   typedef enum logic [1:0] {
      LK_WAIT = 2'b01,
      LK_TRACK = 2'b10
   } rbs_lock_e;

   // Control word, laid out on bits 15..0.
   typedef struct packed {
      rbs_mode_e  mode;
      logic       rsvd13;
      logic       two;
      logic [4:0] training_len_count;
      logic       rsvd6;
      logic       div3Sel;
      logic [2:0] div2Sel;
      logic [1:0] div1Sel;
   } rbs_ctrl_s;

   // Outputs that travel to the external controller together.
   typedef struct packed {
      logic rxData;
      logic dataClk;
      logic rxFlag;
   } rbs_link_s;

endpackage : rbs_pkg

// >>> testbench/rbs_bit_sync_assertions.sv
`timescale 1ns/1ps
module rbs_bit_sync_assertions (
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               rst,
   // Register bus
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   // Receive path
   input wire logic               sliceIn,
   input wire rbs_pkg::rbs_link_s linkOut
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic [1:0] mode;
   logic [2:0] age;
   logic       seen;
   logic       ctrlWr;
   logic       modeChg;
   logic       settled;
   assign ctrlWr  = psel && penable && pready && pwrite && paddr == rbs_pkg::ADDR_CTRL;
   assign modeChg = ctrlWr && pwdata[15:14] != mode;
   assign settled = age == 3'h7;
   // A mode change flushes the outputs, so all but a_flag_rise are judged only once it has settled.
   always_ff @(posedge ref_clk) begin
      if (rst) mode <= 2'h0;
      else if (ctrlWr) mode <= pwdata[15:14];
   end
   always_ff @(posedge ref_clk) begin
      if (rst || modeChg) age <= 3'h0;
      else if (!settled) age <= age + 3'h1;
   end
   always_ff @(posedge ref_clk) begin
      if (rst || modeChg) seen <= 1'b0;
      else if (settled && $changed(linkOut.rxData)) seen <= 1'b1;
   end
   property p_raw_quiet;
      settled && mode == 2'h0 |-> !linkOut.dataClk && !linkOut.rxFlag;
   endproperty
   a_raw_quiet: assert property (p_raw_quiet)
      else $error("raw mode clock or flag");
   property p_raw_pass;
      settled && mode == 2'h0 |-> linkOut.rxData == $past(sliceIn, 3);
   endproperty
   a_raw_pass: assert property (p_raw_pass)
      else $error("raw data not passed");
   property p_flag_mode;
      settled && mode != 2'h3 |-> !linkOut.rxFlag;
   endproperty
   a_flag_mode: assert property (p_flag_mode)
      else $error("flag outside training mode");
   property p_flag_rise;
      $rose(linkOut.rxFlag) |-> $rose(linkOut.dataClk);
   endproperty
   a_flag_rise: assert property (p_flag_rise)
      else $error("flag rose off clock");
   property p_flag_fall;
      settled && $fell(linkOut.rxFlag) |-> $rose(linkOut.dataClk);
   endproperty
   a_flag_fall: assert property (p_flag_fall)
      else $error("flag not one bit long");
   property p_rec_data;
      settled && mode[1] && $changed(linkOut.rxData) |-> !linkOut.dataClk;
   endproperty
   a_rec_data: assert property (p_rec_data)
      else $error("recovered data moved with clock high");
   property p_deg_data;
      settled && mode == 2'h1 && $changed(linkOut.rxData) |-> $rose(linkOut.dataClk);
   endproperty
   a_deg_data: assert property (p_deg_data)
      else $error("filtered data off clock rise");
   property p_first_edge;
      settled && mode[1] && $rose(linkOut.dataClk) |-> seen;
   endproperty
   a_first_edge: assert property (p_first_edge)
      else $error("clock before first data edge");
endmodule : rbs_bit_sync_assertions

bind rbs_bit_sync rbs_bit_sync_assertions chk (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sliceIn(sliceIn), .linkOut(linkOut)
);

// >>> testbench/rbs_mcu_model.sv
`timescale 1ns/1ps
module rbs_mcu_model (
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               rst,
   // Link from the receiver
   input wire rbs_pkg::rbs_link_s link,
   // Observations
   output int                     flagCount,
   output logic                   flagBit,
   output int                     riseDelay,
   output int                     risePeriod
);
   logic prevClk;
   int   sinceFall;
   int   sinceRise;
   // The data clock is polled like a port pin, so its edges cost one cycle to see.
   always_ff @(posedge ref_clk) begin
      prevClk   <= link.dataClk;
      sinceFall <= (prevClk && !link.dataClk) ? 1 : sinceFall + 1;
      sinceRise <= (!prevClk && link.dataClk) ? 1 : sinceRise + 1;
      if (rst) begin
         flagCount <= 0;
      end else if (!prevClk && link.dataClk) begin
         riseDelay  <= sinceFall;
         risePeriod <= sinceRise;
         if (link.rxFlag) begin
            flagCount <= flagCount + 1;
            flagBit   <= link.rxData;
         end
      end
   end
endmodule : rbs_mcu_model

// >>> testbench/test_rbs_bit_sync.sv
`timescale 1ns/1ps
module test_rbs_bit_sync;
   logic               ref_clk = 1'b0;
   logic               rst = 1'b1;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic               sliceIn = 1'b0;
   logic               pready;
   logic               pslverr;
   logic               irq;
   logic               err;
   logic               flagBit;
   logic [31:0]        prdata;
   logic [31:0]        rd;
   logic [15:0]        cw;
   logic [4:0]         tc;
   rbs_pkg::rbs_link_s linkOut;
   int                 flagCount;
   int                 riseDelay;
   int                 risePeriod;
   int                 n_errors = 0;
   int                 check_count = 0;

   always #2 ref_clk = ~ref_clk;

   rbs_bit_sync uut (
      .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sliceIn(sliceIn), .linkOut(linkOut), .irq(irq)
   );
   rbs_mcu_model peer (
      .ref_clk(ref_clk), .rst(rst), .link(linkOut), .flagCount(flagCount),
      .flagBit(flagBit), .riseDelay(riseDelay), .risePeriod(risePeriod)
   );

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic stop_test();
      $display("Checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) n_errors++;
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic drive(input logic b, input int n, input logic chk, input logic e);
      sliceIn <= b;
      repeat (n) begin
         @(posedge ref_clk);
         if (chk) check("filtered data", 32'(e), 32'(linkOut.rxData));
      end
   endtask : drive

   function automatic logic pat(input logic two, input int i);
      return two ? !i[1] : !i[0];
   endfunction : pat

   function automatic int tbmin(input logic two, input logic [4:0] tc);
      return 4 * int'(tc) + int'(two) + 2;
   endfunction : tbmin

   // Bits last 32 cycles to match divisors 1, 2 and 16; runs stay far below the drift limit.
   task automatic train(input logic two, input logic [4:0] tc, input int n, input int exp);
      int   f0;
      logic brk;
      f0  = flagCount;
      brk = pat(two, two ? n - 2 : n - 1);
      apb(1'b1, rbs_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, rbs_pkg::ADDR_CTRL, {16'h0, 2'h3, 1'b0, two, tc, 7'h24});
      drive(1'b0, 128, 1'b0, 1'b0);
      for (int i = 0; i < n; i++) drive(pat(two, i), 32, 1'b0, 1'b0);
      drive(brk, 128, 1'b0, 1'b0);
      check("flag pulses", 32'(exp), 32'(flagCount - f0));
      if (exp > 0) check("flag bit", 32'(brk), 32'(flagBit));
      check("rise offset", 32'h10, riseDelay);
      check("bit period", 32'h20, risePeriod);
   endtask : train

   initial begin
      #100000;
      n_errors++;
      stop_test();
   end

   initial begin
      void'($urandom(32'hA1A3));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      apb(1'b0, rbs_pkg::ADDR_CTRL, 32'h0);
      check("ctrl reset", 32'(rbs_pkg::CTRL_RESET), rd);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped error", 32'h1, 32'(err));
      repeat (3) begin
         cw = 16'($urandom) & 16'hDFBF;
         apb(1'b1, rbs_pkg::ADDR_CTRL, 32'(cw));
         apb(1'b0, rbs_pkg::ADDR_CTRL, 32'h0);
         check("ctrl readback", 32'(cw), rd & 32'hDFBF);
      end
      apb(1'b1, rbs_pkg::ADDR_CTRL, 32'h0);
      repeat (64) drive(1'($urandom), 1, 1'b0, 1'b0);
      apb(1'b1, rbs_pkg::ADDR_CTRL, 32'h4024);
      for (int v = 0; v < 2; v++) begin
         drive(1'(v), 40, 1'b0, 1'b0);
         drive(1'(v), 20, 1'b1, 1'(v));
         drive(1'(~v), 8, 1'b1, 1'(v));
         drive(1'(v), 20, 1'b1, 1'(v));
      end
      check("sample period", 32'h2, risePeriod);
      apb(1'b1, rbs_pkg::ADDR_CTRL, 32'h8024);
      repeat (10) drive(1'($urandom), 32, 1'b0, 1'b0);
      // Divisors 5, 1 and 15 give a 75-cycle bit with its centre seven ticks in.
      apb(1'b1, rbs_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, rbs_pkg::ADDR_CTRL, 32'h8001);
      drive(1'b0, 100, 1'b0, 1'b0);
      drive(1'b1, 400, 1'b0, 1'b0);
      check("bit period 15", 32'(5 * 15), risePeriod);
      check("rise offset 15", 32'(5 * (15 / 2)), riseDelay);
      apb(1'b0, rbs_pkg::ADDR_STATE, 32'h0);
      check("state locked data", 32'h3, rd & 32'h3);
      for (int k = 0; k < 2; k++) begin
         tc = 5'(1 + $urandom % 2);
         train(1'(k), tc, tbmin(1'(k), tc) + 3, 1);
         if (k == 0) begin
            check("irq masked", 32'h0, 32'(irq));
            apb(1'b1, rbs_pkg::ADDR_MASK, 32'h1);
            repeat (2) @(posedge ref_clk);
            check("irq raised", 32'h1, 32'(irq));
            apb(1'b0, rbs_pkg::ADDR_STATUS, 32'h0);
            check("status bit", 32'h1, rd & 32'h1);
            repeat (2) @(posedge ref_clk);
            check("irq cleared", 32'h0, 32'(irq));
         end
         train(1'(k), tc, tbmin(1'(k), tc) - 3, 0);
      end
      stop_test();
   end
endmodule : test_rbs_bit_sync
